// ### pkg/sfm_cfg.svh
`ifndef SFM_CFG_SVH
`define SFM_CFG_SVH

// ==================================================
// Register offsets (byte addresses)
`define SFM_OFS_CTRL 8'h00
`define SFM_OFS_HSF 8'h04
`define SFM_OFS_VSF 8'h08
`define SFM_OFS_AP_PIX 8'h0c
`define SFM_OFS_AP_LINE 8'h10
`define SFM_OFS_OUT_SIZE 8'h14
`define SFM_OFS_PHASES 8'h18
`define SFM_OFS_COEF_WR 8'h1c
`define SFM_OFS_BANK 8'h20
`define SFM_OFS_START_PH 8'h24
`define SFM_OFS_STATUS 8'h28
`define SFM_OFS_REJ_CLR 8'h2c

// ==================================================
// Field positions
`define SFM_FLD_HI_LSB 16
`define SFM_FLD_SRC_MEM 16
`define SFM_FLD_COEF_DIS 17

// ==================================================
// Build-time constants
`define SFM_CTRL_WORD 32'h00000003
`define SFM_HSF 24'h100000
`define SFM_VSF 24'h100000
`define SFM_AP_START_PIX 16'h0010
`define SFM_AP_END_PIX 16'h04ff
`define SFM_AP_START_LINE 16'h0008
`define SFM_AP_END_LINE 16'h02cf
`define SFM_OUT_H_SIZE 16'h0500
`define SFM_OUT_V_SIZE 16'h02d0
`define SFM_H_PHASES 6'h05
`define SFM_V_PHASES 6'h03
`define SFM_TAPS 4
`define SFM_COEF_UNITY 16'h1000
`define SFM_REJ_MAX 16'hffff

`endif

// ### pkg/sfm_pkg.sv
// ==================================================
// Shared types
package sfm_pkg;
	typedef logic [31:0] sfm_word_type;
	typedef logic [23:0] sfm_sf_type;
	typedef logic [15:0] sfm_dim_type;
	typedef logic [5:0] sfm_phase_type;
	typedef logic [15:0] sfm_coef_type;
	typedef enum logic [1:0] {
		SFM_ST_IDLE = 2'b01,
		SFM_ST_RUN = 2'b10
	} sfm_state_type;
endpackage : sfm_pkg

// ### sim/sfm_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sfm_host_model (
	// Clock
	input wire logic clk_i,
	// Register port
	output logic [7:0] addr_o,
	output sfm_pkg::sfm_word_type wr_data_o,
	output logic wr_strb_o,
	output logic rd_strb_o,
	input wire sfm_pkg::sfm_word_type rd_data_i
);
	import sfm_pkg::*;

	// Bus master runs on the core clock itself, well inside the ratio limit
	initial begin
		addr_o = 8'h00;
		wr_data_o = 32'h00000000;
		wr_strb_o = 1'b0;
		rd_strb_o = 1'b0;
	end

	// One-cycle write; address and data scrambled once released
	task wr(input logic [7:0] a, input sfm_word_type d);
		@(posedge clk_i);
		addr_o <= a;
		wr_data_o <= d;
		wr_strb_o <= 1'b1;
		@(posedge clk_i);
		wr_strb_o <= 1'b0;
		addr_o <= ~a;
		wr_data_o <= ~d;
	endtask : wr

	// One-cycle read; data taken in the cycle after the strobe
	task rd(input logic [7:0] a, output sfm_word_type d);
		@(posedge clk_i);
		addr_o <= a;
		rd_strb_o <= 1'b1;
		@(posedge clk_i);
		rd_strb_o <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rd_data_i;
	endtask : rd
endmodule : sfm_host_model
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfm_cfg.svh"

module testbench;
	import sfm_pkg::*;

	// ==================================================
	// Signals
	logic core_clk_i, rst_b_i, wr_strb, rd_strb, src_mem, in_fs, out_fs, h_step, v_step;
	logic [7:0] addr;
	logic [1:0] tap;
	sfm_word_type wr_data, rd_data, ctrl_word;
	sfm_sf_type hsf, vsf;
	sfm_dim_type asp, aep, asl, ael, sph, ohs, ovs;
	sfm_phase_type hph, vph;
	sfm_coef_type coef;
	logic coef_wr_en, running;
	int n_fail, compares, cycles;

	// Clock, 40 ns period
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end

	sfm_host_model u_host (.clk_i(core_clk_i), .addr_o(addr), .wr_data_o(wr_data),
		.wr_strb_o(wr_strb), .rd_strb_o(rd_strb), .rd_data_i(rd_data));

	sfm_top u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr),
		.wr_data_i(wr_data), .wr_strb_i(wr_strb), .rd_strb_i(rd_strb), .rd_data_o(rd_data),
		.src_mem_i(src_mem), .in_frame_start_i(in_fs), .out_frame_start_i(out_fs),
		.h_step_i(h_step), .v_step_i(v_step), .coef_tap_i(tap), .ctrl_word_o(ctrl_word),
		.hsf_o(hsf), .vsf_o(vsf), .ap_start_pix_o(asp), .ap_end_pix_o(aep),
		.ap_start_line_o(asl), .ap_end_line_o(ael), .start_phase_o(sph), .h_phase_o(hph),
		.v_phase_o(vph), .coef_o(coef), .coef_wr_en_o(coef_wr_en), .running_o(running),
		.out_h_size_o(ohs), .out_v_size_o(ovs));

	// ==================================================
	// Checking and closing
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task finish_test;
		$display("mismatches %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	// Hang guard
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			finish_test;
		end
	end

	// One-cycle pulse on a frame input, checked after the taking edge
	task frame(input logic outstage);
		@(posedge core_clk_i);
		if (outstage) out_fs <= 1'b1; else in_fs <= 1'b1;
		@(posedge core_clk_i);
		out_fs <= 1'b0;
		in_fs <= 1'b0;
		#1;
	endtask : frame

	// ==================================================
	// Scenarios
	task t_consts;
		chk("ctrl", `SFM_CTRL_WORD, ctrl_word);
		chk("hsf", {8'h00, `SFM_HSF}, {8'h00, hsf});
		chk("vsf", {8'h00, `SFM_VSF}, {8'h00, vsf});
		chk("start_phase", 32'h0, {16'h0, sph});
		chk("coef_wr_en", 32'h0, {31'h0, coef_wr_en});
		chk("running", 32'h0, {31'h0, running});
	endtask : t_consts

	task t_regs;
		logic [7:0] a [11];
		logic [31:0] e [11];
		sfm_word_type d;
		a = '{`SFM_OFS_CTRL, `SFM_OFS_HSF, `SFM_OFS_VSF, `SFM_OFS_AP_PIX, `SFM_OFS_AP_LINE,
			`SFM_OFS_OUT_SIZE, `SFM_OFS_PHASES, `SFM_OFS_COEF_WR, `SFM_OFS_BANK,
			`SFM_OFS_START_PH, 8'h3c};
		e = '{`SFM_CTRL_WORD, {8'h0, `SFM_HSF}, {8'h0, `SFM_VSF},
			{`SFM_AP_END_PIX, `SFM_AP_START_PIX}, {`SFM_AP_END_LINE, `SFM_AP_START_LINE},
			{`SFM_OUT_V_SIZE, `SFM_OUT_H_SIZE}, {10'h0, `SFM_V_PHASES, 10'h0, `SFM_H_PHASES},
			32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 11; i++) begin
			u_host.rd(a[i], d);
			chk("reg", e[i], d);
			#40;
			chk("rd_idle", 32'h0, rd_data);
		end
	endtask : t_regs

	task t_reject;
		sfm_word_type d;
		u_host.wr(`SFM_OFS_HSF, 32'h00000001);
		u_host.wr(`SFM_OFS_COEF_WR, 32'h00000005);
		u_host.wr(`SFM_OFS_CTRL, 32'h00000000);
		u_host.rd(`SFM_OFS_STATUS, d);
		chk("status", 32'h00020003, d);
		chk("hsf_kept", {8'h0, `SFM_HSF}, {8'h0, hsf});
		chk("ctrl_kept", `SFM_CTRL_WORD, ctrl_word);
		chk("wr_en", 32'h0, {31'h0, coef_wr_en});
		u_host.wr(`SFM_OFS_REJ_CLR, 32'h00000000);
		u_host.rd(`SFM_OFS_STATUS, d);
		chk("status_clr", 32'h00020000, d);
	endtask : t_reject

	task t_aperture;
		sfm_word_type d;
		@(posedge core_clk_i);
		src_mem <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		frame(1'b0);
		chk("asp_mem", 32'h0, {16'h0, asp});
		chk("asl_mem", 32'h0, {16'h0, asl});
		chk("aep_mem", {16'h0, `SFM_AP_END_PIX}, {16'h0, aep});
		chk("ael_mem", {16'h0, `SFM_AP_END_LINE}, {16'h0, ael});
		chk("running", 32'h1, {31'h0, running});
		u_host.rd(`SFM_OFS_STATUS, d);
		chk("status_mem", 32'h00030000, d);
		@(posedge core_clk_i);
		src_mem <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		frame(1'b0);
		frame(1'b0);
		chk("asp_live", {16'h0, `SFM_AP_START_PIX}, {16'h0, asp});
		chk("asl_live", {16'h0, `SFM_AP_START_LINE}, {16'h0, asl});
		chk("hsf_frame", {8'h0, `SFM_HSF}, {8'h0, hsf});
		frame(1'b1);
		chk("out_h", {16'h0, `SFM_OUT_H_SIZE}, {16'h0, ohs});
		chk("out_v", {16'h0, `SFM_OUT_V_SIZE}, {16'h0, ovs});
	endtask : t_aperture

	task t_phase;
		int p;
		for (int i = 1; i <= 7; i++) begin
			@(posedge core_clk_i);
			h_step <= 1'b1;
			v_step <= 1'b1;
			@(posedge core_clk_i);
			h_step <= 1'b0;
			v_step <= 1'b0;
			p = i % 5;
			for (int t = 0; t < 2; t++) begin
				@(posedge core_clk_i);
				tap <= t[1:0];
				repeat (2) @(posedge core_clk_i);
				#1;
				chk("coef", (t == 0) ? 4096 - p * 4096 / 5 : p * 4096 / 5, {16'h0, coef});
			end
			chk("h_phase", p, {26'h0, hph});
			chk("v_phase", i % 3, {26'h0, vph});
		end
		frame(1'b0);
		chk("h_phase_rst", 32'h0, {26'h0, hph});
	endtask : t_phase

	// ==================================================
	// Main sequence
	initial begin
		n_fail = 0;
		compares = 0;
		cycles = 0;
		rst_b_i = 1'b0;
		{src_mem, in_fs, out_fs, h_step, v_step} = 5'h00;
		tap = 2'h0;
		repeat (16) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		#1;
		t_consts;
		t_regs;
		t_reject;
		t_aperture;
		t_phase;
		finish_test;
	end
endmodule : testbench
`default_nettype wire

// ### src/sfm_coef_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfm_cfg.svh"

module sfm_coef_store (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Read port
	input wire logic rd_en_i,
	input wire sfm_pkg::sfm_phase_type phase_i,
	input wire logic [1:0] tap_i,
	output sfm_pkg::sfm_coef_type coef_o
);
	import sfm_pkg::*;

	localparam int NENT = 32'(`SFM_H_PHASES) * `SFM_TAPS;

	// ==================================================
	// Single stored set, fixed at build time
	sfm_coef_type coef_mem [0:NENT-1];

	// Two-tap linear set; taps beyond the first two are zero
	genvar gi;
	generate
		for (gi = 0; gi < NENT; gi++) begin : g_ent
			localparam int PH = gi / `SFM_TAPS;
			localparam int TP = gi % `SFM_TAPS;
			localparam int W1 = PH * 4096 / 32'(`SFM_H_PHASES);
			assign coef_mem[gi] = (TP == 0) ? 16'(4096 - W1) : ((TP == 1) ? 16'(W1) : 16'h0000);
		end
	endgenerate

	// Registered read; out-of-range phases read zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			coef_o <= 16'h0000;
		end else if (rd_en_i) begin
			if (phase_i < `SFM_H_PHASES) begin
				coef_o <= coef_mem[5'(phase_i * 6'(`SFM_TAPS)) + 5'(tap_i)];
			end else begin
				coef_o <= 16'h0000;
			end
		end
	end
endmodule : sfm_coef_store
`default_nettype wire

// ### src/sfm_top.sv
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_cfg.svh"

module sfm_top (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire sfm_pkg::sfm_word_type wr_data_i,
	input wire logic wr_strb_i,
	input wire logic rd_strb_i,
	output sfm_pkg::sfm_word_type rd_data_o,
	// Frame control
	input wire logic src_mem_i,
	input wire logic in_frame_start_i,
	input wire logic out_frame_start_i,
	input wire logic h_step_i,
	input wire logic v_step_i,
	input wire logic [1:0] coef_tap_i,
	// Processing parameters
	output sfm_pkg::sfm_word_type ctrl_word_o,
	output sfm_pkg::sfm_sf_type hsf_o,
	output sfm_pkg::sfm_sf_type vsf_o,
	output sfm_pkg::sfm_dim_type ap_start_pix_o,
	output sfm_pkg::sfm_dim_type ap_end_pix_o,
	output sfm_pkg::sfm_dim_type ap_start_line_o,
	output sfm_pkg::sfm_dim_type ap_end_line_o,
	output sfm_pkg::sfm_dim_type start_phase_o,
	output sfm_pkg::sfm_phase_type h_phase_o,
	output sfm_pkg::sfm_phase_type v_phase_o,
	output sfm_pkg::sfm_coef_type coef_o,
	output logic coef_wr_en_o,
	output logic running_o,
	// Output stage parameters
	output sfm_pkg::sfm_dim_type out_h_size_o,
	output sfm_pkg::sfm_dim_type out_v_size_o
);
	import sfm_pkg::*;

	// ==================================================
	// Reset release
	logic rst_q1;
	logic rst_n;
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// ==================================================
	// Source select pin synchroniser
	logic src_q1;
	logic src_mem;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			src_q1 <= 1'b0;
			src_mem <= 1'b0;
		end else begin
			src_q1 <= src_mem_i;
			src_mem <= src_q1;
		end
	end

	// ==================================================
	// Frame state
	sfm_state_type state;
	sfm_state_type next_state;
	always_comb begin
		next_state = state;
		case (state)
			SFM_ST_IDLE: begin
				if (in_frame_start_i) begin
					next_state = SFM_ST_RUN;
				end
			end
			SFM_ST_RUN: begin
				next_state = SFM_ST_RUN;
			end
			default: begin
				next_state = SFM_ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= SFM_ST_IDLE;
			running_o <= 1'b0;
		end else begin
			state <= next_state;
			running_o <= (next_state == SFM_ST_RUN);
		end
	end

	// ==================================================
	// Aperture in effect for the coming frame
	sfm_dim_type next_ap_start_pix;
	sfm_dim_type next_ap_start_line;
	always_comb begin
		if (src_mem) begin
			next_ap_start_pix = 16'h0000;
			next_ap_start_line = 16'h0000;
		end else begin
			next_ap_start_pix = `SFM_AP_START_PIX;
			next_ap_start_line = `SFM_AP_START_LINE;
		end
	end

	// Processing copy loaded at each input frame start
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_word_o <= `SFM_CTRL_WORD;
			hsf_o <= `SFM_HSF;
			vsf_o <= `SFM_VSF;
			ap_start_pix_o <= `SFM_AP_START_PIX;
			ap_end_pix_o <= `SFM_AP_END_PIX;
			ap_start_line_o <= `SFM_AP_START_LINE;
			ap_end_line_o <= `SFM_AP_END_LINE;
			start_phase_o <= 16'h0000;
		end else if (in_frame_start_i) begin
			ctrl_word_o <= `SFM_CTRL_WORD;
			hsf_o <= `SFM_HSF;
			vsf_o <= `SFM_VSF;
			ap_start_pix_o <= next_ap_start_pix;
			ap_end_pix_o <= `SFM_AP_END_PIX;
			ap_start_line_o <= next_ap_start_line;
			ap_end_line_o <= `SFM_AP_END_LINE;
			start_phase_o <= 16'h0000;
		end
	end

	// Output stage copy taken from the processing stage
	sfm_dim_type proc_out_h;
	sfm_dim_type proc_out_v;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			proc_out_h <= `SFM_OUT_H_SIZE;
			proc_out_v <= `SFM_OUT_V_SIZE;
			out_h_size_o <= `SFM_OUT_H_SIZE;
			out_v_size_o <= `SFM_OUT_V_SIZE;
		end else begin
			if (in_frame_start_i) begin
				proc_out_h <= `SFM_OUT_H_SIZE;
				proc_out_v <= `SFM_OUT_V_SIZE;
			end
			if (out_frame_start_i) begin
				out_h_size_o <= proc_out_h;
				out_v_size_o <= proc_out_v;
			end
		end
	end

	// ==================================================
	// Phase counters with arbitrary modulus
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			h_phase_o <= 6'h00;
			v_phase_o <= 6'h00;
		end else if (in_frame_start_i) begin
			h_phase_o <= 6'h00;
			v_phase_o <= 6'h00;
		end else begin
			if (h_step_i) begin
				h_phase_o <= (h_phase_o == `SFM_H_PHASES - 6'h01) ? 6'h00 : h_phase_o + 6'h01;
			end
			if (v_step_i) begin
				v_phase_o <= (v_phase_o == `SFM_V_PHASES - 6'h01) ? 6'h00 : v_phase_o + 6'h01;
			end
		end
	end

	// ==================================================
	// Coefficient store, single set, no bank select
	sfm_coef_store u_coef (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.rd_en_i(1'b1),
		.phase_i(h_phase_o),
		.tap_i(coef_tap_i),
		.coef_o(coef_o)
	);

	// Coefficient write path held off
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			coef_wr_en_o <= 1'b0;
		end else begin
			coef_wr_en_o <= 1'b0;
		end
	end

	// ==================================================
	// Rejected write counter; clear register is the only write taken
	sfm_dim_type rej_cnt;
	logic rej_clr;
	assign rej_clr = wr_strb_i && (addr_i == `SFM_OFS_REJ_CLR);
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rej_cnt <= 16'h0000;
		end else if (rej_clr) begin
			rej_cnt <= 16'h0000;
		end else if (wr_strb_i && rej_cnt != `SFM_REJ_MAX) begin
			rej_cnt <= rej_cnt + 16'h0001;
		end
	end

	// ==================================================
	// Read mux; data stand one cycle after the strobe only
	sfm_word_type next_rd;
	always_comb begin
		case (addr_i)
			`SFM_OFS_CTRL: next_rd = `SFM_CTRL_WORD;
			`SFM_OFS_HSF: next_rd = {8'h00, hsf_o};
			`SFM_OFS_VSF: next_rd = {8'h00, vsf_o};
			`SFM_OFS_AP_PIX: next_rd = {ap_end_pix_o, ap_start_pix_o};
			`SFM_OFS_AP_LINE: next_rd = {ap_end_line_o, ap_start_line_o};
			`SFM_OFS_OUT_SIZE: next_rd = {out_v_size_o, out_h_size_o};
			`SFM_OFS_PHASES: next_rd = {10'h000, `SFM_V_PHASES, 10'h000, `SFM_H_PHASES};
			`SFM_OFS_COEF_WR: next_rd = 32'h00000000;
			`SFM_OFS_BANK: next_rd = 32'h00000000;
			`SFM_OFS_START_PH: next_rd = 32'h00000000;
			`SFM_OFS_STATUS: next_rd = {14'h0000, 1'b1, src_mem, rej_cnt};
			default: next_rd = 32'h00000000;
		endcase
	end

	// Read data register
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_o <= 32'h00000000;
		end else begin
			rd_data_o <= rd_strb_i ? next_rd : 32'h00000000;
		end
	end

	// ==================================================
	// Checks
	property p_ctrl_fixed;
		@(posedge core_clk_i) disable iff (!rst_n)
		ctrl_word_o == `SFM_CTRL_WORD;
	endproperty
	a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("control word not 3");

	property p_mem_zero;
		@(posedge core_clk_i) disable iff (!rst_n)
		(src_mem && in_frame_start_i) |=> (ap_start_pix_o == 16'h0000 && ap_start_line_o == 16'h0000);
	endproperty
	a_mem_zero: assert property (p_mem_zero) else $error("memory aperture start not zero");

	property p_live_crop;
		@(posedge core_clk_i) disable iff (!rst_n)
		(!src_mem && in_frame_start_i) |=>
			(ap_start_pix_o == `SFM_AP_START_PIX && ap_end_line_o == `SFM_AP_END_LINE);
	endproperty
	a_live_crop: assert property (p_live_crop) else $error("live aperture wrong");

	property p_h_wrap;
		@(posedge core_clk_i) disable iff (!rst_n)
		(h_step_i && !in_frame_start_i && h_phase_o == `SFM_H_PHASES - 6'h01) |=>
			(h_phase_o == 6'h00);
	endproperty
	a_h_wrap: assert property (p_h_wrap) else $error("h phase did not wrap at 5");

	property p_v_range;
		@(posedge core_clk_i) disable iff (!rst_n)
		v_step_i |=> (v_phase_o < `SFM_V_PHASES);
	endproperty
	a_v_range: assert property (p_v_range) else $error("v phase out of range");

	property p_coef_off;
		@(posedge core_clk_i) disable iff (!rst_n)
		wr_strb_i |-> ##1 !coef_wr_en_o [*3];
	endproperty
	a_coef_off: assert property (p_coef_off) else $error("coefficient write enabled");

	property p_sf_const;
		@(posedge core_clk_i) disable iff (!rst_n)
		wr_strb_i |=> (hsf_o == `SFM_HSF && $stable(vsf_o));
	endproperty
	a_sf_const: assert property (p_sf_const) else $error("scale factor changed by write");

	property p_bank_zero;
		@(posedge core_clk_i) disable iff (!rst_n)
		(rd_strb_i && (addr_i == `SFM_OFS_BANK || addr_i == `SFM_OFS_START_PH)) |=>
			(rd_data_o == 32'h00000000);
	endproperty
	a_bank_zero: assert property (p_bank_zero) else $error("bank or start phase not zero");

	property p_start_ph;
		@(posedge core_clk_i) disable iff (!rst_n)
		in_frame_start_i |=> (start_phase_o == 16'h0000 && h_phase_o == 6'h00);
	endproperty
	a_start_ph: assert property (p_start_ph) else $error("start phase not zero");

	property p_out_copy;
		@(posedge core_clk_i) disable iff (!rst_n)
		out_frame_start_i |=>
			(out_h_size_o == $past(proc_out_h) && out_v_size_o == `SFM_OUT_V_SIZE);
	endproperty
	a_out_copy: assert property (p_out_copy) else $error("output stage copy wrong");

	// Source used by the last frame load; a source change may move the aperture start
	logic load_src;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			load_src <= 1'b0;
		end else if (in_frame_start_i) begin
			load_src <= src_mem;
		end
	end

	property p_frame_same;
		@(posedge core_clk_i) disable iff (!rst_n)
		(in_frame_start_i && src_mem == load_src) |=>
			($stable(ap_start_pix_o) && $stable(ap_start_line_o) && $stable(hsf_o));
	endproperty
	a_frame_same: assert property (p_frame_same) else $error("parameters changed between frames");

	property p_rd_idle;
		@(posedge core_clk_i) disable iff (!rst_n)
		!rd_strb_i |=> (rd_data_o == 32'h00000000);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

	property p_run_on;
		@(posedge core_clk_i) disable iff (!rst_n)
		in_frame_start_i |=> running_o;
	endproperty
	a_run_on: assert property (p_run_on) else $error("not running after frame start");

endmodule : sfm_top
`default_nettype wire
